// file: dram_strobe_map.svh
// register offsets, field positions and reset values of the strobe block
// assumes inclusion by name from every file that decodes the map
`ifndef DRAM_STROBE_MAP_SVH
`define DRAM_STROBE_MAP_SVH

`define CONFIG_OFFSET        12'h000
`define STATUS_OFFSET        12'h004
`define CONFIG_RESET         32'h0000_0000
`define CONFIG_WRITE_MASK    32'h0000_F400
`define CFG_ADS_DELAY_BIT    10
`define CFG_DEPTH_LSB        12
`define CFG_DEPTH_MSB        13
`define CFG_BANK_LAYOUT_BIT  14
`define CFG_MEM_TYPE_BIT     15
`define MEM_SPACE_CODE       2'h0
`define SPACE_MSB            31
`define SPACE_LSB            30
`define BANK_256K_LSB        20
`define BANK_1M_LSB          22
`define BANK_4M_LSB          24
`define DEPTH_256K           2'h0
`define DEPTH_1M             2'h1
`define RAS_ALL_OFF          4'hF
`define RAS_LOWER_PAIR       4'h3
`define RAS_ALL_BANKS        4'hF

`endif

// file: dram_strobe_pkg.sv
// types shared by the strobe timing block
// assumes the map header supplies the register map constants
package dram_strobe_pkg;

  typedef enum logic {mem_edo, mem_fpm} mem_type_type;

  typedef enum logic [1:0] {acc_idle, acc_active, acc_refresh}
    access_state_type;

  typedef logic [10:0] dram_addr_type;

endpackage : dram_strobe_pkg

// file: dram_strobe_timing_control.sv
// row/column strobe timing for fpm and edo dram modules, apb configured
// assumes a wait-state machine on pclk supplies beat, cas and address data
`include "dram_strobe_map.svh"
`timescale 1ns/1ps

module dram_strobe_timing_control
(
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           address_strobe_n,
  input  wire logic [31:0]                    processor_addr_bus,
  input  wire logic                           access_read,
  input  wire logic                           beat_ready,
  input  wire logic                           burst_last,
  input  wire logic                           cas_request,
  input  wire logic                           refresh_request,
  input  wire dram_strobe_pkg::dram_addr_type row_addr,
  input  wire dram_strobe_pkg::dram_addr_type col_addr,
  output logic                                ready_ack,
  output logic      [3:0]                     ras_n,
  output logic                                cas_n,
  output dram_strobe_pkg::dram_addr_type      dram_addr
);
  import dram_strobe_pkg::*;

  logic [31:0]      config_reg;
  logic             ads_s1;
  logic             ads_s2;
  logic [31:0]      addr_s1;
  logic [31:0]      addr_s2;
  logic             ads_dly;
  logic [31:0]      addr_dly;
  logic             ads_use;
  logic [31:0]      addr_use;
  logic             access_start;
  logic [1:0]       bank_bits;
  logic [3:0]       bank_ras;
  logic [3:0]       enabled_ras;
  logic [3:0]       ras_line;
  logic [3:0]       next_ras;
  access_state_type state;
  logic             cas_on;
  logic             next_cas;
  logic             col_fresh;
  logic             addr_is_row;
  mem_type_type     mem_type;
  logic             dual_bank;
  logic             ads_delay_on;
  logic [1:0]       depth;
  logic             setup_phase;
  logic             access_phase;
  logic             addr_hit;

  assign mem_type     = config_reg[`CFG_MEM_TYPE_BIT] ? mem_fpm : mem_edo;
  assign dual_bank    = config_reg[`CFG_BANK_LAYOUT_BIT];
  assign ads_delay_on = config_reg[`CFG_ADS_DELAY_BIT];
  assign depth        = config_reg[`CFG_DEPTH_MSB:`CFG_DEPTH_LSB];

  // apb slave: zero wait, answer flopped in setup so outputs are registered
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable && pready;
  assign addr_hit     = (paddr == `CONFIG_OFFSET) ||
                        (paddr == `STATUS_OFFSET);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !addr_hit;
      if (setup_phase && !pwrite && paddr == `CONFIG_OFFSET)
        prdata <= config_reg;
      else if (setup_phase && !pwrite && paddr == `STATUS_OFFSET)
        prdata <= {24'h00_0000, ~ras_n, 1'b0, cas_on,
                   state == acc_refresh, state == acc_active};
      else
        prdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      config_reg <= `CONFIG_RESET;
    else if (access_phase && pwrite && paddr == `CONFIG_OFFSET)
      config_reg <= pwdata & `CONFIG_WRITE_MASK;
  end

  // pins from the processor bus pass two flops first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ads_s1  <= 1'b1;
      ads_s2  <= 1'b1;
      addr_s1 <= 32'h0000_0000;
      addr_s2 <= 32'h0000_0000;
    end
    else
    begin
      ads_s1  <= address_strobe_n;
      ads_s2  <= ads_s1;
      addr_s1 <= processor_addr_bus;
      addr_s2 <= addr_s1;
    end
  end

  // delayed copy buys a settling cycle at the cost of one wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ads_dly  <= 1'b0;
      addr_dly <= 32'h0000_0000;
    end
    else
    begin
      ads_dly  <= !ads_s2;
      addr_dly <= addr_s2;
    end
  end

  assign ads_use  = ads_delay_on ? ads_dly : !ads_s2;
  assign addr_use = ads_delay_on ? addr_dly : addr_s2;
  assign access_start = ads_use &&
    (addr_use[`SPACE_MSB:`SPACE_LSB] == `MEM_SPACE_CODE);

  always_comb
  begin
    unique case (depth)
      `DEPTH_256K: bank_bits = addr_use[`BANK_256K_LSB +: 2];
      `DEPTH_1M:   bank_bits = addr_use[`BANK_1M_LSB +: 2];
      default:     bank_bits = addr_use[`BANK_4M_LSB +: 2];
    endcase
  end

  // dual order keeps one dual-bank module contiguous: 0,2,1,3
  always_comb
  begin
    bank_ras = 4'h0;
    if (dual_bank)
      bank_ras[{bank_bits[0], bank_bits[1]}] = 1'b1;
    else if (!bank_bits[1])
      bank_ras[bank_bits[0]] = 1'b1;
  end

  assign enabled_ras = dual_bank ? `RAS_ALL_BANKS : `RAS_LOWER_PAIR;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= acc_idle;
      ras_line <= 4'h0;
    end
    else
    begin
      unique case (state)
        acc_idle:
          if (access_start)
          begin
            state    <= acc_active;
            ras_line <= bank_ras;
          end
          else if (refresh_request)
          begin
            state    <= acc_refresh;
            ras_line <= enabled_ras;
          end
        acc_active:
          if (beat_ready && burst_last)
          begin
            state    <= acc_idle;
            ras_line <= 4'h0;
          end
        acc_refresh:
          if (!refresh_request)
          begin
            state    <= acc_idle;
            ras_line <= 4'h0;
          end
      endcase
    end
  end

  always_comb
  begin
    next_ras = 4'h0;
    if (state == acc_idle && access_start)
      next_ras = bank_ras;
    else if (state == acc_idle && refresh_request)
      next_ras = enabled_ras;
    else if (state == acc_active && !(beat_ready && burst_last))
      next_ras = ras_line;
    else if (state == acc_refresh && refresh_request)
      next_ras = ras_line;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ras_n <= `RAS_ALL_OFF;
    else
      ras_n <= ~(next_ras & enabled_ras);
  end

  // ready follows every beat in window even with no bank mapped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ready_ack <= 1'b0;
    else
      ready_ack <= (state == acc_active) && beat_ready;
  end

  // fpm waits out a fresh column; fpm read holds until data is taken
  always_comb
  begin
    next_cas = 1'b0;
    unique case (mem_type)
      mem_edo: next_cas = cas_request;
      mem_fpm: next_cas = (cas_request && !col_fresh) ||
                          (access_read && cas_on && !ready_ack);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cas_on <= 1'b0;
      cas_n  <= 1'b1;
    end
    else
    begin
      cas_on <= next_cas && (state == acc_active);
      cas_n  <= !(next_cas && (state == acc_active));
    end
  end

  // column moves on the falling edge, half a cycle after row strobe
  always_ff @(negedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dram_addr   <= 11'h000;
      col_fresh   <= 1'b0;
      addr_is_row <= 1'b1;
    end
    else if (ras_n == `RAS_ALL_OFF)
    begin
      dram_addr   <= row_addr;
      col_fresh   <= 1'b0;
      addr_is_row <= 1'b1;
    end
    else
    begin
      dram_addr   <= col_addr;
      col_fresh   <= addr_is_row || (col_addr != dram_addr);
      addr_is_row <= 1'b0;
    end
  end

  ready_window_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == acc_active && beat_ready) |=> ready_ack)
    else $error("beat in window without ready");

  fpm_cas_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mem_type == mem_fpm && access_read && cas_on && !ready_ack &&
     state == acc_active && !(beat_ready && burst_last)) ##0
    $stable(config_reg) |=> cas_on)
    else $error("fpm read column strobe dropped early");

  edo_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mem_type == mem_edo && state == acc_active && !cas_request &&
     $stable(config_reg)) |=> cas_n)
    else $error("edo column strobe not released");

  ras_next_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == acc_idle && access_start && (bank_ras & enabled_ras) != 4'h0)
    |=> ras_n != `RAS_ALL_OFF)
    else $error("row strobe missing after address cycle");

  ads_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ads_delay_on && $past(ads_delay_on) && !$past(ads_s2))
    |-> ads_use)
    else $error("delayed address strobe lost");

  row_then_col_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(ras_n) == `RAS_ALL_OFF && ras_n != `RAS_ALL_OFF)
    |-> !addr_is_row && $past(addr_is_row))
    else $error("row address not held half a clock");

  refresh_all_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == acc_idle && !access_start && refresh_request)
    |=> ras_n[1:0] == 2'h0)
    else $error("refresh missed an enabled bank");

  single_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!dual_bank && !$past(dual_bank)) |-> ras_n[3:2] == 2'h3)
    else $error("upper row strobe in single bank mode");

  fpm_col_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mem_type == mem_fpm && $past(mem_type) == mem_fpm && $rose(cas_on))
    |-> !$past(col_fresh))
    else $error("fpm column strobe on fresh column");

endmodule : dram_strobe_timing_control

// file: dram_module_model.sv
// dram module model: latches row and column, reports timing seen
// assumes active low strobes and one controller clock
`timescale 1ns/1ps
module dram_module_model
(
  input  wire logic        fpm,
  input  wire logic [3:0]  ras_n,
  input  wire logic        cas_n,
  input  wire logic [10:0] dram_addr,
  output logic      [10:0] row_seen,
  output logic      [10:0] col_seen,
  output real              row_hold,
  output real              col_setup,
  output logic             dq_driven
);
  realtime t_ras = 0;
  realtime t_chg = 0;
  logic    held = 1;

  always @(negedge (&ras_n))
  begin
    row_seen = dram_addr;
    t_ras = $realtime;
    held = 0;
  end

  always @(dram_addr)
  begin
    if (!held)
      row_hold = $realtime - t_ras;
    held = 1;
    t_chg = $realtime;
  end

  always @(negedge cas_n)
  begin
    col_seen = dram_addr;
    col_setup = $realtime - t_chg;
  end

  // fpm lets go with cas, edo holds until both strobes rise
  always @(cas_n or ras_n)
    if (!cas_n)
      dq_driven = 1;
    else if (fpm || &ras_n)
      dq_driven = 0;
endmodule : dram_module_model

// file: dram_strobe_timing_control_bench.sv
// bench for the strobe block: apb config, accesses, refresh
// assumes the dram model watches the memory side pins
`timescale 1ns/1ps
module dram_strobe_timing_control_bench;
  import dram_strobe_pkg::*;
  logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]   paddr = 0;
  logic [31:0]   pwdata = 0, prdata, rd, processor_addr_bus = 0;
  logic          pready, pslverr, er, ready_ack, cas_n, dq_driven, fpm = 0;
  logic          address_strobe_n = 1, access_read = 0, beat_ready = 0;
  logic          burst_last = 0, cas_request = 0, refresh_request = 0;
  dram_addr_type row_addr = 0, col_addr = 0, dram_addr, row_seen, col_seen;
  logic [3:0]    ras_n;
  real           row_hold, col_setup;
  int            mismatches = 0, comparisons = 0, cycles = 0;

  always #12.5 pclk = ~pclk;

  dram_strobe_timing_control dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .address_strobe_n,
    .processor_addr_bus, .access_read, .beat_ready, .burst_last,
    .cas_request, .refresh_request, .row_addr, .col_addr, .ready_ack,
    .ras_n, .cas_n, .dram_addr);
  dram_module_model mem_u (.fpm, .ras_n, .cas_n, .dram_addr, .row_seen,
    .col_seen, .row_hold, .col_setup, .dq_driven);

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // whole run is a few hundred cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic setcfg(input logic [31:0] c);
    apb(1, 12'h000, c);
    apb(0, 12'h000, 32'h0000_0000);
    chk(rd === (c & 32'h0000_F400), "config readback");
    fpm = c[15];
  endtask : setcfg

  task automatic access(input logic [31:0] a, input logic [3:0] e,
                        input int lat, input logic win);
    int n;
    int got;
    got = 0;
    @(posedge pclk);
    processor_addr_bus <= a;
    address_strobe_n <= 0;
    row_addr <= a[12:2];
    col_addr <= ~a[12:2];
    for (n = 1; n <= 8; n++)
    begin
      @(posedge pclk);
      address_strobe_n <= 1;
      @(negedge pclk);
      if (ras_n !== 4'hF && got == 0)
        got = n;
    end
    chk(got == lat, "ras latency");
    chk(ras_n === e, "ras select");
    if (lat != 0)
    begin
      chk(row_seen === a[12:2], "row addr");
      chk(row_hold > 12.0 && row_hold < 13.0, "row hold");
      @(posedge pclk);
      cas_request <= 1;
      access_read <= 1;
      col_addr <= a[12:2] ^ 11'h155;
      got = 0;
      for (n = 1; n <= 4; n++)
      begin
        @(posedge pclk);
        @(negedge pclk);
        if (cas_n === 1'b0 && got == 0)
          got = n;
      end
      chk(got == (fpm ? 2 : 1), "cas latency");
      chk(col_seen === (a[12:2] ^ 11'h155), "col addr");
      chk(fpm ? col_setup > 24.0 : col_setup < 13.0, "col setup");
    end
    if (win)
    begin
      @(posedge pclk);
      beat_ready <= 1;
      burst_last <= 1;
      access_read <= 1;
      cas_request <= 0;
      @(posedge pclk);
      beat_ready <= 0;
      burst_last <= 0;
      access_read <= 0;
      got = 0;
      for (n = 1; n <= 4; n++)
      begin
        @(negedge pclk);
        if (ready_ack === 1'b1)
        begin
          got++;
          chk(lat == 0 || !fpm || dq_driven === 1'b1, "data at ack");
        end
        @(posedge pclk);
      end
      chk(got == 1, "ready ack");
      chk(ras_n === 4'hF && cas_n === 1'b1, "release");
    end
  endtask : access

  task automatic t_regs;
    chk(ras_n === 4'hF && cas_n === 1'b1, "reset strobes");
    apb(0, 12'h000, 32'h0000_0000);
    chk(rd === 32'h0000_0000 && er === 1'b0, "config reset");
    setcfg(32'hFFFF_FFFF);
    apb(1, 12'h008, 32'hFFFF_FFFF);
    apb(0, 12'h008, 32'h0000_0000);
    chk(rd === 32'h0000_0000 && er === 1'b1, "unmapped");
    $display("test registers done");
  endtask : t_regs

  task automatic t_banks;
    logic [31:0] c [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_5000,
                           32'h0000_5000, 32'h0000_7000};
    logic [31:0] ad [5] = '{32'h0000_0000, 32'h0010_0000, 32'h0040_0000,
                            32'h0080_0000, 32'h03C0_0000};
    logic [3:0]  ex [5] = '{4'hE, 4'hD, 4'hB, 4'hD, 4'h7};
    for (int i = 0; i < 5; i++)
    begin
      setcfg(c[i]);
      access(ad[i], ex[i], 3, 1);
    end
    $display("test banks done");
  endtask : t_banks

  task automatic t_modes;
    setcfg(32'h0000_0400);
    access(32'h0000_0000, 4'hE, 4, 1);
    setcfg(32'h0000_8000);
    access(32'h0010_0000, 4'hD, 3, 1);
    setcfg(32'h0000_0000);
    access(32'h3FF0_0000, 4'hF, 0, 1);
    access(32'h4000_0000, 4'hF, 0, 0);
    $display("test modes done");
  endtask : t_modes

  task automatic refresh(input logic [31:0] c, input logic [3:0] e);
    setcfg(c);
    @(posedge pclk);
    refresh_request <= 1;
    @(posedge pclk);
    @(negedge pclk);
    chk(ras_n === e, "refresh strobes");
    @(posedge pclk);
    refresh_request <= 0;
    @(posedge pclk);
    @(negedge pclk);
    chk(ras_n === 4'hF, "refresh end");
    $display("test refresh done");
  endtask : refresh

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_banks();
    t_modes();
    refresh(32'h0000_0000, 4'hC);
    refresh(32'h0000_4000, 4'h0);
    report_and_stop();
  end
endmodule : dram_strobe_timing_control_bench
